// file: rtl/afr_frontend_ctrl.sv
// Purpose: amplifier, reference and clock-source control with status flags
// Assumes: comparator levels synchronous to sys_clk_i, register port byte wide
// Notes:   analog decisions leave as registered control levels
`timescale 1ns/1ps
module afr_frontend_ctrl (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             soft_reset_i,
    // register port
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic             reg_wr_i,
    input  wire logic [7:0]       reg_wdata_i,
    output logic      [7:0]       reg_rdata_o,
    // analog monitors
    input  wire afr_pkg::afr_rail_t rail_cmp_i,
    input  wire logic             ref0_low_i,
    input  wire logic             ref1_low_i,
    input  wire logic             converting_i,
    input  wire logic             power_down_i,
    // analog controls
    output afr_pkg::afr_ctrl_t    ctrl_o,
    output logic                  ref_low_any_o
);
    import afr_pkg::*;

    logic [7:0]  gain_w, rate_w, refctl_w, exc1_w, status_w;
    afr_rail_t   rail_reg, rail_next;
    logic [1:0]  reflow_reg, reflow_next;
    afr_ctrl_t   ctrl_reg, ctrl_next;

    afr_regfile u_regs (
        .sys_clk_i    (sys_clk_i),
        .reset_n_i    (reset_n_i),
        .soft_reset_i (soft_reset_i),
        .addr_i       (reg_addr_i),
        .wr_en_i      (reg_wr_i),
        .wr_data_i    (reg_wdata_i),
        .status_i     (status_w),
        .rd_data_o    (reg_rdata_o),
        .gain_o       (gain_w),
        .rate_o       (rate_w),
        .refctl_o     (refctl_w),
        .exc1_o       (exc1_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic rail_en(input logic [7:0] exc);
        rail_en = exc[AFR_RAILEN_BIT];
    endfunction : rail_en

    always_comb begin
        if (rail_en(exc1_w)) begin
            rail_next = rail_cmp_i;
        end else begin
            rail_next = '0;
        end
        // reference monitor, only sampled while converting
        reflow_next = reflow_reg;
        if (converting_i) begin
            reflow_next = {ref1_low_i, ref0_low_i};
        end
        if (soft_reset_i) begin
            rail_next   = '0;
            reflow_next = 2'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rail_reg   <= '0;
            reflow_reg <= 2'h0;
        end else begin
            rail_reg   <= rail_next;
            reflow_reg <= reflow_next;
        end
    end

    assign status_w      = {rail_reg, 2'h0, reflow_reg};
    assign ref_low_any_o = |reflow_reg;

    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]    gain_code;
    afr_amp_mode_t amp_mode;
    logic [1:0]    refpwr;

    always_comb begin
        gain_code = gain_w[AFR_GAIN_LSB +: 3];
        amp_mode  = afr_amp_mode_t'(gain_w[AFR_AMPEN_LSB +: 2]);
        refpwr    = refctl_w[AFR_REFPWR_LSB +: 2];
        ctrl_next = '0;
        // amplifier power and bypass; reserved codes act as off
        ctrl_next.amp_power  = (amp_mode == AFR_AMP_ON);
        ctrl_next.amp_bypass = (amp_mode != AFR_AMP_ON);
        if (gain_code > AFR_GAIN_32) begin
            ctrl_next.analog_gain   = AFR_GAIN_32;
            ctrl_next.digital_shift = 2'(gain_code - AFR_GAIN_32);
        end else begin
            ctrl_next.analog_gain   = gain_code;
            ctrl_next.digital_shift = 2'h0;
        end
        ctrl_next.ref_route = refctl_w[AFR_REFSEL_LSB +: 2];
        ctrl_next.int_ref_on = (refpwr == 2'b10) || ((refpwr == 2'b01) && !power_down_i);
        ctrl_next.pos_buf_on = !refctl_w[AFR_PBUF_BIT];
        ctrl_next.neg_buf_on = !refctl_w[AFR_NBUF_BIT];
        ctrl_next.ext_clk_sel = rate_w[AFR_CLKSEL_BIT];
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_o = ctrl_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_rail_gate_off: assert property (!exc1_w[AFR_RAILEN_BIT] |=> rail_reg == '0)
        else $error("rail flags set while detection disabled");
    a_rail_follow: assert property ((exc1_w[AFR_RAILEN_BIT] && !soft_reset_i)
        |=> rail_reg == $past(rail_cmp_i))
        else $error("rail flags do not follow comparators");
    a_amp_off: assert property (gain_w[AFR_AMPEN_LSB +: 2] == AFR_AMP_OFF
        |=> ctrl_o.amp_bypass && !ctrl_o.amp_power)
        else $error("amplifier not bypassed for code 00");
    a_gain_cap: assert property (gain_w[AFR_GAIN_LSB +: 3] > AFR_GAIN_32
        |=> ctrl_o.analog_gain == AFR_GAIN_32)
        else $error("analog gain exceeds 32");
    a_ref_int: assert property (refctl_w[AFR_REFSEL_LSB +: 2] == AFR_REF_INT
        |=> ctrl_o.ref_route == AFR_REF_INT)
        else $error("internal reference not routed");
    a_ref_pwr: assert property ((refctl_w[AFR_REFPWR_LSB +: 2] == 2'b01 && power_down_i)
        |=> !ctrl_o.int_ref_on)
        else $error("reference not off in power down");
    a_buf_low: assert property (refctl_w[AFR_PBUF_BIT] |=> !ctrl_o.pos_buf_on)
        else $error("positive buffer enabled by 1");
    a_clk_reset: assert property (soft_reset_i |=> ##1 !ctrl_o.ext_clk_sel)
        else $error("clock not back to oscillator");
    a_reflow_hold: assert property (!converting_i && !soft_reset_i |=> $stable(reflow_reg))
        else $error("reference flags moved outside conversion");

    c_bypass: cover property (gain_w[AFR_AMPEN_LSB +: 2] == AFR_AMP_OFF ##1 ctrl_o.amp_bypass);
    c_ext_clk: cover property (ctrl_o.ext_clk_sel);
    c_rail_hit: cover property (rail_reg != '0);
    c_ref_low: cover property (ref_low_any_o);

endmodule : afr_frontend_ctrl

// file: rtl/afr_pkg.sv
// Purpose: shared constants and types for the front-end, reference and clock control
// Assumes: byte-wide register port, offsets are register addresses
// Notes:   comparator inputs arrive already synchronous to sys_clk_i
package afr_pkg;

    localparam logic [7:0] AFR_ADDR_STATUS = 8'h01;
    localparam logic [7:0] AFR_ADDR_GAIN   = 8'h03;
    localparam logic [7:0] AFR_ADDR_RATE   = 8'h04;
    localparam logic [7:0] AFR_ADDR_REFCTL = 8'h05;
    localparam logic [7:0] AFR_ADDR_EXC1   = 8'h06;

    // field positions
    localparam int AFR_GAIN_LSB      = 0;
    localparam int AFR_AMPEN_LSB     = 5;
    localparam int AFR_CLKSEL_BIT    = 6;
    localparam int AFR_REFPWR_LSB    = 0;
    localparam int AFR_REFSEL_LSB    = 2;
    localparam int AFR_NBUF_BIT      = 4;
    localparam int AFR_PBUF_BIT      = 5;
    localparam int AFR_RAILEN_BIT    = 7;

    // reset values
    localparam logic [7:0] AFR_GAIN_RST   = 8'h00;
    localparam logic [7:0] AFR_RATE_RST   = 8'h14;
    localparam logic [7:0] AFR_REFCTL_RST = 8'h10;
    localparam logic [7:0] AFR_EXC1_RST   = 8'h00;

    localparam logic [2:0] AFR_GAIN_32  = 3'h5;
    localparam logic [2:0] AFR_GAIN_1   = 3'h0;

    // timing, informative for host side settling
    localparam int AFR_CLK_MHZ        = 100;
    localparam int AFR_REF_SETTLE_US  = 4500;
    localparam int AFR_REF_SETTLE_CYC = AFR_REF_SETTLE_US * AFR_CLK_MHZ;

    typedef enum logic [1:0] {
        AFR_AMP_OFF = 2'b00,
        AFR_AMP_ON  = 2'b01,
        AFR_AMP_R2  = 2'b10,
        AFR_AMP_R3  = 2'b11
    } afr_amp_mode_t;

    typedef enum logic [1:0] {
        AFR_REF_EXT0 = 2'b00,
        AFR_REF_EXT1 = 2'b01,
        AFR_REF_INT  = 2'b10,
        AFR_REF_RSV  = 2'b11
    } afr_ref_sel_t;

    typedef struct packed {
        logic       pos_out_near_high_rail;
        logic       pos_out_near_low_rail;
        logic       neg_out_near_high_rail;
        logic       neg_out_near_low_rail;
    } afr_rail_t;

    typedef struct packed {
        logic       amp_power;
        logic       amp_bypass;
        logic [2:0] analog_gain;
        logic [1:0] digital_shift;
        logic [1:0] ref_route;
        logic       int_ref_on;
        logic       pos_buf_on;
        logic       neg_buf_on;
        logic       ext_clk_sel;
    } afr_ctrl_t;

endpackage : afr_pkg

// file: rtl/afr_regfile.sv
// Purpose: configuration byte store for the control block
// Assumes: one write per cycle, read data registered
// Notes:   reset restores defaults, including internal oscillator choice
`timescale 1ns/1ps
module afr_regfile (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       soft_reset_i,
    // access
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [7:0] status_i,
    output logic      [7:0] rd_data_o,
    output logic      [7:0] gain_o,
    output logic      [7:0] rate_o,
    output logic      [7:0] refctl_o,
    output logic      [7:0] exc1_o
);
    import afr_pkg::*;

    logic [7:0] gain_reg, gain_next, rate_reg, rate_next;
    logic [7:0] refctl_reg, refctl_next, exc1_reg, exc1_next;
    logic [7:0] rd_reg, rd_next;

    always_comb begin
        gain_next   = gain_reg;
        rate_next   = rate_reg;
        refctl_next = refctl_reg;
        exc1_next   = exc1_reg;
        unique case (addr_i)
            AFR_ADDR_STATUS: rd_next = status_i;
            AFR_ADDR_GAIN:   rd_next = gain_reg;
            AFR_ADDR_RATE:   rd_next = rate_reg;
            AFR_ADDR_REFCTL: rd_next = refctl_reg;
            AFR_ADDR_EXC1:   rd_next = exc1_reg;
            default:         rd_next = 8'h00;
        endcase
        if (wr_en_i) begin
            unique case (addr_i)
                AFR_ADDR_GAIN:   gain_next   = wr_data_i;
                AFR_ADDR_RATE:   rate_next   = wr_data_i;
                AFR_ADDR_REFCTL: refctl_next = wr_data_i;
                AFR_ADDR_EXC1:   exc1_next   = wr_data_i;
                default:         ;
            endcase
        end
        if (soft_reset_i) begin
            gain_next   = AFR_GAIN_RST;
            rate_next   = AFR_RATE_RST;
            refctl_next = AFR_REFCTL_RST;
            exc1_next   = AFR_EXC1_RST;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gain_reg   <= AFR_GAIN_RST;
            rate_reg   <= AFR_RATE_RST;
            refctl_reg <= AFR_REFCTL_RST;
            exc1_reg   <= AFR_EXC1_RST;
            rd_reg     <= 8'h00;
        end else begin
            gain_reg   <= gain_next;
            rate_reg   <= rate_next;
            refctl_reg <= refctl_next;
            exc1_reg   <= exc1_next;
            rd_reg     <= rd_next;
        end
    end

    assign rd_data_o = rd_reg;
    assign gain_o    = gain_reg;
    assign rate_o    = rate_reg;
    assign refctl_o  = refctl_reg;
    assign exc1_o    = exc1_reg;

endmodule : afr_regfile

// file: sim/afr_host_model.sv
// Purpose: host side of the register port, issues byte writes and reads
// Assumes: inputs of the block sampled at the rising edge
// Notes:   write data goes to its inverse once released
`timescale 1ns/1ps
module afr_host_model (
    // clock
    input  wire logic       sys_clk_i,
    // register port
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o
);
    import afr_pkg::*;
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        // bypass only at unity gain, no reserved codes
        if (a == AFR_ADDR_GAIN && d[6:5] != 2'b01) begin
            d = 8'h00;
        end
        if (a == AFR_ADDR_REFCTL && d[3:2] == 2'b10) begin
            d[5:4] = 2'b11;
        end
        // sources stay off, so no settling wait is owed
        if (a == AFR_ADDR_EXC1) begin
            d[6:0] = 7'h00;
        end
        @(negedge sys_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        @(negedge sys_clk_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : afr_host_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for the front-end control block
// Assumes: expectations follow the register field layout
// Notes:   random values from a fixed-seed shift register
`timescale 1ns/1ps
module tb_top;
    import afr_pkg::*;
    logic       sys_clk_i    = 1'b0;
    logic       reset_n_i    = 1'b0;
    logic       soft_reset_i = 1'b0;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    afr_rail_t  rail_cmp     = '0;
    logic       ref0_low     = 1'b0;
    logic       ref1_low     = 1'b0;
    logic       converting   = 1'b0;
    logic       power_down   = 1'b0;
    afr_ctrl_t  ctrl;
    logic       ref_low_any;
    int         fails        = 0;
    int         checked      = 0;
    logic [7:0] lfsr         = 8'h44;
    logic [7:0] v, r1, r2, r3;
    logic [2:0] code;
    logic [1:0] sel, pwr, bb;
    always #5 sys_clk_i = ~sys_clk_i;
    afr_frontend_ctrl u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .soft_reset_i(soft_reset_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .rail_cmp_i(rail_cmp),
        .ref0_low_i(ref0_low), .ref1_low_i(ref1_low), .converting_i(converting),
        .power_down_i(power_down), .ctrl_o(ctrl), .ref_low_any_o(ref_low_any));
    afr_host_model u_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : rnd
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_byte(n, {7'h00, e}, {7'h00, g});
    endtask : chk_bit
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    initial begin
        #200000;
        fails++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk_bit("amp_bypass", 1'b1, ctrl.amp_bypass);
        chk_byte("ref_route", 8'h00, {6'h00, ctrl.ref_route});
        chk_bit("int_ref_on", 1'b0, ctrl.int_ref_on);
        chk_bit("ext_clk_sel", 1'b0, ctrl.ext_clk_sel);
        chk_bit("neg_buf_on", 1'b0, ctrl.neg_buf_on);
        chk_bit("pos_buf_on", 1'b1, ctrl.pos_buf_on);
        u_host.rd(AFR_ADDR_REFCTL, v);
        chk_byte("refctl", AFR_REFCTL_RST, v);
        u_host.rd(AFR_ADDR_RATE, v);
        chk_byte("rate", AFR_RATE_RST, v);
        u_host.wr(8'h02, 8'hff);
        u_host.rd(8'h02, v);
        chk_byte("unmapped", 8'h00, v);
        for (int c = 0; c < 8; c++) begin
            u_host.wr(AFR_ADDR_GAIN, {3'b001, 2'b00, c[2:0]});
            repeat (2) @(negedge sys_clk_i);
            code = (c > 5) ? AFR_GAIN_32 : c[2:0];
            chk_byte("analog_gain", {5'h00, code}, {5'h00, ctrl.analog_gain});
            sel = (c == 7) ? 2'h2 : ((c == 6) ? 2'h1 : 2'h0);
            chk_byte("digital_shift", {6'h00, sel}, {6'h00, ctrl.digital_shift});
            chk_bit("amp_power", 1'b1, ctrl.amp_power);
        end
        for (int i = 0; i < 24; i++) begin
            r1 = rnd();
            r2 = rnd();
            r3 = rnd();
            code = r1[0] ? r1[3:1] : 3'h0;
            sel = (r2[5:4] == 2'b11) ? 2'b10 : r2[5:4];
            pwr = (r2[1:0] == 2'b11) ? 2'b10 : r2[1:0];
            bb = (sel == 2'b10) ? 2'b11 : r2[7:6];
            power_down = r2[2];
            rail_cmp = r3[3:0];
            ref0_low = r3[4];
            ref1_low = r3[5];
            converting = 1'b1;
            u_host.wr(AFR_ADDR_GAIN, {2'b00, r1[0], 2'b00, code});
            u_host.wr(AFR_ADDR_REFCTL, {2'b00, bb, sel, pwr});
            u_host.wr(AFR_ADDR_RATE, {1'b0, r2[3], 6'h14});
            u_host.wr(AFR_ADDR_EXC1, {r3[7], 7'h00});
            repeat (2) @(negedge sys_clk_i);
            chk_bit("amp_power", r1[0], ctrl.amp_power);
            chk_bit("amp_bypass", !r1[0], ctrl.amp_bypass);
            chk_byte("ref_route", {6'h00, sel}, {6'h00, ctrl.ref_route});
            chk_bit("int_ref_on", pwr == 2'b10 || (pwr == 2'b01 && !r2[2]),
                    ctrl.int_ref_on);
            chk_bit("pos_buf_on", !bb[1], ctrl.pos_buf_on);
            chk_bit("neg_buf_on", !bb[0], ctrl.neg_buf_on);
            chk_bit("ext_clk_sel", r2[3], ctrl.ext_clk_sel);
            u_host.rd(AFR_ADDR_STATUS, v);
            chk_byte("rail", {(r3[7] ? r3[3:0] : 4'h0), 4'h0}, {v[7:4], 4'h0});
            chk_byte("ref_low", {6'h00, r3[5:4]}, {6'h00, v[1:0]});
            chk_bit("ref_low_any", r3[5] | r3[4], ref_low_any);
        end
        converting = 1'b0;
        ref0_low   = ~r3[4];
        ref1_low   = ~r3[5];
        repeat (3) @(negedge sys_clk_i);
        u_host.rd(AFR_ADDR_STATUS, v);
        chk_byte("ref_hold", {6'h00, r3[5:4]}, {6'h00, v[1:0]});
        converting = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk_bit("ref_low_any", ~(r3[5] & r3[4]), ref_low_any);
        u_host.wr(AFR_ADDR_RATE, 8'h54);
        repeat (2) @(negedge sys_clk_i);
        chk_bit("ext_clk_sel", 1'b1, ctrl.ext_clk_sel);
        soft_reset_i = 1'b1;
        @(negedge sys_clk_i);
        soft_reset_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk_bit("ext_clk_sel", 1'b0, ctrl.ext_clk_sel);
        u_host.wr(AFR_ADDR_RATE, 8'h54);
        repeat (2) @(negedge sys_clk_i);
        chk_bit("ext_clk_sel", 1'b1, ctrl.ext_clk_sel);
        reset_n_i = 1'b0;
        @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk_bit("ext_clk_sel", 1'b0, ctrl.ext_clk_sel);
        u_host.rd(AFR_ADDR_RATE, v);
        chk_byte("rate", AFR_RATE_RST, v);
        conclude();
    end
endmodule : tb_top
